// ==== rtl/fpsb_activity.v ====
`timescale 1ns/1ps
`include "fpsb_map.vh"

// Flags a synchronised input as alive while it keeps changing within TMO cycles
module fpsb_activity #(
    parameter       CW  = 8,
    parameter       TMO = 16
) (
    // Clock and reset
    input  wire         clock_i,
    input  wire         nrst_i,
    input  wire         ce_i,
    // Monitored level, already synchronised
    input  wire         level_i,
    // Status
    output reg          alive_o,
    output wire         rise_o
);

    localparam [CW-1:0] TMO_C = TMO[CW-1:0];

    reg          last;
    reg [CW-1:0] idle_cnt;
    wire         change = level_i ^ last;

    assign rise_o = level_i & ~last;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last     <= 1'b0;
            idle_cnt <= {CW{1'b0}};
            alive_o  <= 1'b0;
        end else if (ce_i) begin
            last <= level_i;
            if (change) begin
                idle_cnt <= {CW{1'b0}};
                alive_o  <= 1'b1;
            end else if (idle_cnt >= TMO_C - 1'b1) begin
                alive_o  <= 1'b0;
            end else begin
                idle_cnt <= idle_cnt + 1'b1;
            end
        end
    end

endmodule // fpsb_activity

// ==== rtl/fpsb_panel.v ====
// Functional notes
// - Clock, sync and gate connector pins are each bidirectional.
// - Master role drives clock, sync and gate outward to slaves.
// - Slave role takes clock, sync and gate from the bus as inputs.
// - Master lamp lit exactly while configured as bus master.
// - Link lamp lit once the PCIe link is trained and valid.
// - User lamp has no fixed function; user logic drives it.
// - PPS lamp lit only while a valid PPS input is detected.
// - PPS lamp blinks once per received pulse while valid.
// - Thermal lamp is the OR of all temperature and voltage alarms.
// - Clock lamp lit while a valid sample clock is detected.
// - No converter data is passed on while no sample clock exists.
// - Four overload lamps, each from overload detect or FIFO overrun.
`timescale 1ns/1ps
`include "fpsb_map.vh"

module fpsb_panel #(
    parameter PPS_TMO_CYC = `FPSB_PPS_TMO_CYC,
    parameter BLINK_CYC   = `FPSB_BLINK_CYC
) (
    // Clock, reset, enable
    input  wire                        clock_i,
    input  wire                        nrst_i,
    input  wire                        ce_i,
    // Role and status from on-chip logic
    input  wire                        timing_lead_i,
    input  wire                        pcie_up_i,
    input  wire                        user_defined_i,
    // Asynchronous inputs
    input  wire                        pps_i,
    input  wire [`FPSB_NSENS-1:0]      sensor_alarm_i,
    input  wire                        sample_clk_div_i,
    input  wire [`FPSB_NCHAN-1:0]      adc_ovr_detect_i,
    // Per-channel FIFO overrun and source select
    input  wire [`FPSB_NCHAN-1:0]      fifo_overrun_i,
    input  wire [`FPSB_NCHAN-1:0]      clip_src_fifo_i,
    // Internal timing signals for master drive
    input  wire [`FPSB_TBUS_W-1:0]     tbus_local_i,
    // Timing-bus pins
    input  wire [`FPSB_TBUS_W-1:0]     tbus_pin_i,
    output reg  [`FPSB_TBUS_W-1:0]     tbus_pin_o,
    output reg  [`FPSB_TBUS_W-1:0]     tbus_pin_oe_o,
    // Timing signals used by the board
    output reg  [`FPSB_TBUS_W-1:0]     tbus_use_o,
    // Converter data stream gate
    input  wire                        adc_valid_i,
    output reg                         adc_valid_o,
    // Lamps
    output reg                         pcie_up_led_o,
    output reg                         user_defined_led_o,
    output reg                         timing_lead_led_o,
    output reg                         pps_led_o,
    output reg                         thermal_alarm_led_o,
    output reg                         clk_led_o,
    output reg  [`FPSB_NCHAN-1:0]      adc_clip_led_o
);

    localparam [`FPSB_LONG_W-1:0] PPS_TMO_C = PPS_TMO_CYC[`FPSB_LONG_W-1:0];
    localparam [`FPSB_LONG_W-1:0] BLINK_C   = BLINK_CYC[`FPSB_LONG_W-1:0];

    // Synchronised copies
    wire                       pps_s;
    wire [`FPSB_NSENS-1:0]     alarm_s;
    wire                       sclk_s;
    wire [`FPSB_NCHAN-1:0]     ovr_s;
    wire [`FPSB_TBUS_W-1:0]    tbus_s;

    fpsb_sync2 #(.W(1)) u_sync_pps (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .async_i (pps_i),
        .sync_o  (pps_s)
    );

    fpsb_sync2 #(.W(`FPSB_NSENS)) u_sync_alarm (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .async_i (sensor_alarm_i),
        .sync_o  (alarm_s)
    );

    fpsb_sync2 #(.W(1)) u_sync_sclk (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .async_i (sample_clk_div_i),
        .sync_o  (sclk_s)
    );

    fpsb_sync2 #(.W(`FPSB_NCHAN)) u_sync_ovr (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .async_i (adc_ovr_detect_i),
        .sync_o  (ovr_s)
    );

    fpsb_sync2 #(.W(`FPSB_TBUS_W)) u_sync_tbus (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .async_i (tbus_pin_i),
        .sync_o  (tbus_s)
    );

    // Sample clock presence: a divided copy must keep toggling
    wire sclk_alive;

    fpsb_activity #(
        .CW  (`FPSB_SCLK_CNT_W),
        .TMO (`FPSB_SCLK_TMO_CYC)
    ) u_sclk_mon (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .level_i (sclk_s),
        .alive_o (sclk_alive),
        .rise_o  ()
    );

    // Nonzero test shared by the blink counter and the lamp
    function fpsb_cnt_live;
        input [`FPSB_LONG_W-1:0] cnt;
        begin
            fpsb_cnt_live = (cnt != {`FPSB_LONG_W{1'b0}});
        end
    endfunction

    // PPS validity and blink
    reg                      pps_last;
    reg                      pps_valid;
    reg [`FPSB_LONG_W-1:0]   pps_gap;
    reg [`FPSB_LONG_W-1:0]   blink_cnt;
    wire                     pps_rise = pps_s & ~pps_last;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pps_last  <= 1'b0;
            pps_valid <= 1'b0;
            // Start saturated so a lone first pulse after reset is not taken as valid
            pps_gap   <= PPS_TMO_C;
            blink_cnt <= {`FPSB_LONG_W{1'b0}};
        end else if (ce_i) begin
            pps_last <= pps_s;
            if (pps_rise) begin
                // Valid only after a second edge inside the window
                pps_valid <= (pps_gap < PPS_TMO_C);
                pps_gap   <= {`FPSB_LONG_W{1'b0}};
                blink_cnt <= BLINK_C;
            end else begin
                if (pps_gap < PPS_TMO_C) begin
                    pps_gap <= pps_gap + 1'b1;
                end else begin
                    pps_valid <= 1'b0;
                end
                if (fpsb_cnt_live(blink_cnt)) begin
                    blink_cnt <= blink_cnt - 1'b1;
                end
            end
        end
    end

    // Overload lamp source per channel
    wire [`FPSB_NCHAN-1:0] clip_src;
    genvar ch;
    generate
        for (ch = 0; ch < `FPSB_NCHAN; ch = ch + 1) begin : g_clip
            // FIFO overrun is already on this clock, overload detect went through two flops
            assign clip_src[ch] = clip_src_fifo_i[ch] ? fifo_overrun_i[ch]
                                                      : ovr_s[ch];
        end
    endgenerate

    // Picks the local timing lines as master, the other source as slave
    function [`FPSB_TBUS_W-1:0] fpsb_pick;
        input                    lead;
        input [`FPSB_TBUS_W-1:0] own;
        input [`FPSB_TBUS_W-1:0] other;
        begin
            fpsb_pick = lead ? own : other;
        end
    endfunction

    // Every line turns together so the bus never half-drives
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tbus_pin_oe_o <= {`FPSB_TBUS_W{1'b0}};
        end else if (ce_i) begin
            tbus_pin_oe_o <= {`FPSB_TBUS_W{timing_lead_i}};
        end
    end

    // Slave keeps the driver at 0 so a stray enable never puts a level on the bus
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tbus_pin_o <= {`FPSB_TBUS_W{1'b0}};
        end else if (ce_i) begin
            tbus_pin_o <= fpsb_pick(timing_lead_i, tbus_local_i,
                                    {`FPSB_TBUS_W{1'b0}});
        end
    end

    // The board always uses the timing that the bus carries in its role
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tbus_use_o <= {`FPSB_TBUS_W{1'b0}};
        end else if (ce_i) begin
            tbus_use_o <= fpsb_pick(timing_lead_i, tbus_local_i, tbus_s);
        end
    end

    // Samples without a live sample clock would be stale, so the gate closes
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            adc_valid_o <= 1'b0;
        end else if (ce_i) begin
            adc_valid_o <= adc_valid_i & sclk_alive;
        end
    end

    // Link lamp
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pcie_up_led_o <= 1'b0;
        end else if (ce_i) begin
            pcie_up_led_o <= pcie_up_i;
        end
    end

    // User lamp carries no meaning of its own
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            user_defined_led_o <= 1'b0;
        end else if (ce_i) begin
            user_defined_led_o <= user_defined_i;
        end
    end

    // Master lamp
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timing_lead_led_o <= 1'b0;
        end else if (ce_i) begin
            timing_lead_led_o <= timing_lead_i;
        end
    end

    // The lamp follows each pulse only while the pulse train is valid
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pps_led_o <= 1'b0;
        end else if (ce_i) begin
            pps_led_o <= pps_valid & fpsb_cnt_live(blink_cnt);
        end
    end

    // Any single sensor is enough to light the alarm
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thermal_alarm_led_o <= 1'b0;
        end else if (ce_i) begin
            thermal_alarm_led_o <= |alarm_s;
        end
    end

    // Clock lamp
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_led_o <= 1'b0;
        end else if (ce_i) begin
            clk_led_o <= sclk_alive;
        end
    end

    // Overload lamps
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            adc_clip_led_o <= {`FPSB_NCHAN{1'b0}};
        end else if (ce_i) begin
            adc_clip_led_o <= clip_src;
        end
    end

endmodule // fpsb_panel

// ==== rtl/fpsb_sync2.v ====
`timescale 1ns/1ps
`include "fpsb_map.vh"

module fpsb_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clock_i,
    input  wire         nrst_i,
    input  wire         ce_i,
    // Data
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
        end else if (ce_i) begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;

endmodule // fpsb_sync2

// ==== shared/fpsb_map.vh ====
`ifndef FPSB_MAP_VH
`define FPSB_MAP_VH

// Timing bus lines: clock, sync, gate
`define FPSB_TBUS_W        3
`define FPSB_TBUS_CLK      0
`define FPSB_TBUS_SYNC     1
`define FPSB_TBUS_GATE     2
// Connector pin count
`define FPSB_CONN_PINS     26
// Converter channels
`define FPSB_NCHAN         4
// Sensor alarm inputs
`define FPSB_NSENS         4
// Clock rate in kHz
`define FPSB_CLK_KHZ       250000
// PPS pulse is called lost after this many ms without an edge
`define FPSB_PPS_TMO_MS    1500
`define FPSB_PPS_TMO_CYC   ((`FPSB_PPS_TMO_MS) * (`FPSB_CLK_KHZ))
// Blink on-time per received pulse, ms
`define FPSB_BLINK_MS      100
`define FPSB_BLINK_CYC     ((`FPSB_BLINK_MS) * (`FPSB_CLK_KHZ))
// Sample clock is lost after this many system cycles without a toggle
`define FPSB_SCLK_TMO_CYC  64
`define FPSB_SCLK_CNT_W    7
// Counter width for the long counts
`define FPSB_LONG_W        29

`endif

// ==== verification/fpsb_panel_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module fpsb_panel_bench;
    logic       clock_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b0, timing_lead_i = 1'b1, pps_i = 1'b0;
    logic       pcie_up_i = 1'b0, user_defined_i = 1'b0, sample_clk_div_i = 1'b0;
    logic       adc_valid_i = 1'b0, peer_lead = 1'b0;
    logic [3:0] sensor_alarm_i = 4'h0, adc_ovr_detect_i = 4'h0, fifo_overrun_i = 4'h0;
    logic [3:0] clip_src_fifo_i = 4'h0, m;
    logic [2:0] tbus_local_i = 3'h0, peer_val = 3'h0;
    wire  [2:0] tbus_pin_i, tbus_pin_o, tbus_pin_oe_o, tbus_use_o;
    wire  [3:0] adc_clip_led_o;
    wire        adc_valid_o, pcie_up_led_o, user_defined_led_o, timing_lead_led_o, pps_led_o;
    wire        thermal_alarm_led_o, clk_led_o;
    int         error_cnt = 0, n_compared = 0;
    fpsb_panel #(.PPS_TMO_CYC(200), .BLINK_CYC(20)) dut (.*);
    fpsb_peer peer (.clock_i(clock_i), .dut_oe_i(tbus_pin_oe_o), .dut_pin_i(tbus_pin_o),
        .peer_lead_i(peer_lead), .peer_val_i(peer_val), .wire_o(tbus_pin_i));
    initial forever #2 clock_i = ~clock_i;
    task cyc(input int n); repeat (n) @(posedge clock_i); endtask
    task look(input int n); repeat (n) @(posedge clock_i); @(negedge clock_i); endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task t_bus;
        cyc(1); tbus_local_i <= 3'h6;
        look(2);
        `CHK("pin_oe", 3'h7, tbus_pin_oe_o)
        `CHK("pin_o", 3'h6, tbus_pin_o)
        `CHK("use_o", 3'h6, tbus_use_o)
        `CHK("lead_led", 1'b1, timing_lead_led_o)
        cyc(1); timing_lead_i <= 1'b0; peer_lead <= 1'b1; peer_val <= 3'h5;
        look(5);
        `CHK("slave_oe", 3'h0, tbus_pin_oe_o)
        `CHK("slave_use", 3'h5, tbus_use_o)
        `CHK("slave_led", 1'b0, timing_lead_led_o)
        cyc(1); peer_val <= 3'h2; look(5);
        `CHK("slave_use2", 3'h2, tbus_use_o)
        cyc(1); peer_lead <= 1'b0; timing_lead_i <= 1'b1;
        $display("test bus done");
    endtask
    task t_stat;
        cyc(1); pcie_up_i <= 1'b1; user_defined_i <= 1'b1; look(2);
        `CHK("link_led", 1'b1, pcie_up_led_o)
        `CHK("user_led", 1'b1, user_defined_led_o)
        for (int i = 0; i < 4; i++) begin
            cyc(1); sensor_alarm_i <= 4'h1 << i; look(4);
            `CHK("therm_led", 1'b1, thermal_alarm_led_o)
        end
        cyc(1); sensor_alarm_i <= 4'h0; pcie_up_i <= 1'b0; user_defined_i <= 1'b0; look(4);
        `CHK("therm_off", 1'b0, thermal_alarm_led_o)
        `CHK("link_off", 1'b0, pcie_up_led_o)
        `CHK("user_off", 1'b0, user_defined_led_o)
        cyc(1); ce_i <= 1'b0; pcie_up_i <= 1'b1; look(3);
        `CHK("frozen", 1'b0, pcie_up_led_o)
        cyc(1); ce_i <= 1'b1; pcie_up_i <= 1'b0;
        cyc(1); nrst_i <= 1'b0; look(1);
        `CHK("rst_oe", 3'h0, tbus_pin_oe_o)
        `CHK("rst_lead", 1'b0, timing_lead_led_o)
        cyc(1); nrst_i <= 1'b1; look(1);
        `CHK("rel_lead", 1'b1, timing_lead_led_o)
        `CHK("rel_oe", 3'h7, tbus_pin_oe_o)
        $display("test status done");
    endtask
    task t_clip;
        for (int i = 0; i < 4; i++) begin
            m = 4'h1 << i;
            cyc(1); adc_ovr_detect_i <= m; fifo_overrun_i <= ~m; clip_src_fifo_i <= 4'h0; look(4);
            `CHK("clip_ovr", m, adc_clip_led_o)
            cyc(1); clip_src_fifo_i <= 4'hf; look(2);
            `CHK("clip_fifo", ~m, adc_clip_led_o)
        end
        cyc(1); adc_ovr_detect_i <= 4'h0; fifo_overrun_i <= 4'h0;
        $display("test clip done");
    endtask
    task t_sclk;
        cyc(1); adc_valid_i <= 1'b1; look(4);
        `CHK("gate_noclk", 1'b0, adc_valid_o)
        `CHK("clk_led_off", 1'b0, clk_led_o)
        repeat (10) begin cyc(4); sample_clk_div_i <= ~sample_clk_div_i; end
        look(1);
        `CHK("clk_led_on", 1'b1, clk_led_o)
        `CHK("gate_clk", 1'b1, adc_valid_o)
        look(80);
        `CHK("clk_led_lost", 1'b0, clk_led_o)
        `CHK("gate_lost", 1'b0, adc_valid_o)
        cyc(1); adc_valid_i <= 1'b0;
        $display("test sample clock done");
    endtask
    task t_pps;
        repeat (3) begin cyc(100); pps_i <= 1'b1; cyc(4); pps_i <= 1'b0; end
        look(6);
        `CHK("pps_blink", 1'b1, pps_led_o)
        look(30);
        `CHK("pps_gap", 1'b0, pps_led_o)
        look(300); cyc(1); pps_i <= 1'b1; cyc(4); pps_i <= 1'b0; look(4);
        `CHK("pps_lone", 1'b0, pps_led_o)
        $display("test pps done");
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        ce_i <= 1'b1;
        t_bus; t_stat; t_clip; t_sclk; t_pps;
        summarize;
    end
    // Tests take about 900 cycles
    initial begin
        #20000;
        error_cnt++;
        summarize;
    end
endmodule // fpsb_panel_bench
bind fpsb_panel fpsb_props #(.PPS_TMO_CYC(PPS_TMO_CYC), .BLINK_CYC(BLINK_CYC)) props (.*);

// ==== verification/fpsb_peer.sv ====
`timescale 1ns/1ps
module fpsb_peer (
    // Clock
    input  wire       clock_i,
    // Our board's pin drive
    input  wire [2:0] dut_oe_i,
    input  wire [2:0] dut_pin_i,
    // Peer master role and the values it sends
    input  wire       peer_lead_i,
    input  wire [2:0] peer_val_i,
    // Resolved bus level
    output wire [2:0] wire_o
);
    logic [2:0] idle = 3'h0;
    // Undriven LVPECL lines have no pull; a changing pattern exposes stale use
    always @(posedge clock_i) begin
        idle <= ~idle;
    end
    assign wire_o = (dut_oe_i & dut_pin_i) | (~dut_oe_i & (peer_lead_i ? peer_val_i : idle));
endmodule // fpsb_peer

// ==== verification/fpsb_props.sv ====
`timescale 1ns/1ps
module fpsb_props #(
    parameter PPS_TMO_CYC = 200,
    parameter BLINK_CYC   = 20
) (
    // Clock, reset and the other panel inputs
    input wire       clock_i, nrst_i, ce_i, timing_lead_i, pcie_up_i, user_defined_i, pps_i,
    input wire       sample_clk_div_i, adc_valid_i,
    input wire [3:0] sensor_alarm_i, adc_ovr_detect_i, fifo_overrun_i, clip_src_fifo_i,
    input wire [2:0] tbus_local_i, tbus_pin_i,
    // Outputs watched
    input wire [2:0] tbus_pin_o, tbus_pin_oe_o, tbus_use_o,
    input wire       adc_valid_o, pcie_up_led_o, user_defined_led_o, timing_lead_led_o,
    input wire       pps_led_o, thermal_alarm_led_o, clk_led_o,
    input wire [3:0] adc_clip_led_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] sq;
    logic [7:0] ph;
    logic [9:0] pq;
    // sq and pq restart while ce_i is low so a frozen block is not charged for time that it did not see; ph keeps counting
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sq <= 8'h00;
            pq <= 10'h000;
            ph <= 8'h00;
        end else begin
            sq <= ($changed(sample_clk_div_i) || !ce_i) ? 8'h00 : sq + (sq != 8'hff);
            pq <= ($changed(pps_i) || !ce_i) ? 10'h000 : pq + (pq != 10'h3ff);
            ph <= pps_led_o ? ph + 8'h01 : 8'h00;
        end
    end
    sequence run3; ce_i [*3]; endsequence
    sequence slave3; (ce_i && !timing_lead_i) [*3]; endsequence
    a_lead_lamp: assert property (ce_i |=> timing_lead_led_o == $past(timing_lead_i))
        else $error("lead lamp wrong");
    a_pin_dir: assert property (ce_i |=> tbus_pin_oe_o == {3{$past(timing_lead_i)}})
        else $error("pin direction wrong");
    a_lead_drive: assert property (ce_i && timing_lead_i |=>
        tbus_pin_o == $past(tbus_local_i) && tbus_use_o == $past(tbus_local_i))
        else $error("master drive wrong");
    a_slave_take: assert property (slave3 |=>
        tbus_use_o == $past(tbus_pin_i, 3) && tbus_pin_o == 3'h0)
        else $error("slave timing wrong");
    a_link_user: assert property (ce_i |=> pcie_up_led_o == $past(pcie_up_i) &&
        user_defined_led_o == $past(user_defined_i)) else $error("link or user lamp wrong");
    a_alarm_or: assert property (run3 |=> thermal_alarm_led_o == |$past(sensor_alarm_i, 3))
        else $error("thermal lamp wrong");
    a_clip_src: assert property (run3 |=> adc_clip_led_o ==
        (($past(clip_src_fifo_i) & $past(fifo_overrun_i)) |
        (~$past(clip_src_fifo_i) & $past(adc_ovr_detect_i, 3)))) else $error("clip lamp wrong");
    a_data_gate: assert property (ce_i |=> adc_valid_o == (clk_led_o && $past(adc_valid_i)))
        else $error("data gate wrong");
    a_sclk_loss: assert property (sq > 8'd72 |-> !clk_led_o)
        else $error("clock lamp stays lit");
    a_pps_quiet: assert property (pq > PPS_TMO_CYC + BLINK_CYC + 8 |-> !pps_led_o)
        else $error("pps lamp lit without pulses");
    a_blink_len: assert property (ph <= BLINK_CYC)
        else $error("pps blink too long");
endmodule // fpsb_props
